// *** include/fdcce_pkg.sv ***
// package of constants for the floppy control-command engine
package fdcce_pkg;
    // =====================================================================
    // register map (byte addresses)
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] RESULT_OFF = 8'h08;
    localparam logic [7:0] CONFIG_OFF = 8'h0C;
    localparam logic [7:0] ID_OFF = 8'h10;
    localparam logic [7:0] PCYL_OFF = 8'h14;
    // =====================================================================
    // command codes in CMD[3:0]; drive in CMD[5:4]; target cylinder in CMD[15:8]
    localparam logic [3:0] OP_READ_ID = 4'hA;
    localparam logic [3:0] OP_RECAL = 4'h7;
    localparam logic [3:0] OP_SEEK = 4'hF;
    localparam logic [3:0] OP_SENSE_INT = 4'h8;
    localparam logic [3:0] OP_SENSE_DRV = 4'h4;
    localparam logic [3:0] OP_POWER_DOWN = 4'h1;
    localparam logic [3:0] OP_POWER_UP = 4'h2;
    // =====================================================================
    // status register zero fields and status register one missing-mark bit
    localparam int ST0_SE_BIT = 5;
    localparam int ST0_EC_BIT = 4;
    localparam int ST0_H_BIT = 2;
    localparam int ST0_IC_LSB = 6;
    localparam logic [1:0] IC_NORMAL = 2'h0;
    localparam logic [1:0] IC_ABNORMAL = 2'h1;
    localparam logic [1:0] IC_POLL = 2'h3;
    localparam int ST1_MA_BIT = 0;
    // =====================================================================
    // status register bit positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RES_BIT = 1;
    localparam int STAT_INT_BIT = 2;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_DBUSY_LSB = 4;
    // =====================================================================
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int STEP_PULSE_NS = 1000;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int SRT_UNIT_US = 500;
    localparam int SRT_UNIT_CYC = SRT_UNIT_US * (CLK_HZ / 1000000);
    localparam logic [7:0] RECAL_MAX_STEPS = 8'd79;
    localparam logic [3:0] SRT_RESET = 4'h8;
    localparam int NUM_DRIVES = 4;
endpackage

// *** src/fdcce_stepper.sv ***
// per-drive head positioner: seek and return to track zero
`timescale 1ns/1ns
`default_nettype none
module fdcce_stepper
    import fdcce_pkg::*;
#(
    parameter int UNIT_CYC = SRT_UNIT_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_seek,
    input wire logic start_recal,
    input wire logic clear_cyl,
    input wire logic [7:0] target,
    input wire logic [3:0] step_rate_interval,
    input wire logic trk0,
    output logic [7:0] cyl,
    output logic step,
    output logic dir,
    output logic active,
    output logic done,
    output logic fail
);
    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT, ST_CHECK} fdcce_stp_t;
    fdcce_stp_t state_reg;
    logic recal_reg;
    logic [7:0] tgt_reg;
    logic [7:0] count_reg;
    logic [23:0] timer_reg;
    logic [23:0] gap_cyc;
    logic at_target;
    logic last_pulse;
    // srt code 0 means the longest interval, as in 16 units
    assign gap_cyc = 24'(UNIT_CYC) * 24'((5'h10 - {1'b0, step_rate_interval}));
    assign at_target = (cyl == tgt_reg);
    assign last_pulse = (count_reg == RECAL_MAX_STEPS);
    assign step = (state_reg == ST_PULSE);
    assign active = (state_reg != ST_IDLE);
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        fail <= 1'b0;
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            recal_reg <= 1'b0;
            tgt_reg <= 8'h00;
            count_reg <= 8'h00;
            timer_reg <= 24'h000000;
            cyl <= 8'h00;
            dir <= 1'b0;
        end
        else if (clear_cyl)
        begin
            state_reg <= ST_IDLE;
            // a cut pulse must not leave its count for the next start
            timer_reg <= 24'h000000;
            cyl <= 8'h00;
        end
        else if (start_recal)
        begin
            cyl <= 8'h00;
            recal_reg <= 1'b1;
            tgt_reg <= 8'h00;
            count_reg <= 8'h00;
            dir <= 1'b0;
            state_reg <= ST_CHECK;
        end
        else if (start_seek)
        begin
            recal_reg <= 1'b0;
            tgt_reg <= target;
            dir <= (cyl < target);
            state_reg <= ST_CHECK;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE: ;
                ST_PULSE:
                begin
                    if (timer_reg == 24'(STEP_PULSE_CYC - 1))
                    begin
                        timer_reg <= 24'h000000;
                        state_reg <= ST_WAIT;
                        if (!recal_reg)
                            cyl <= dir ? cyl + 8'h01 : cyl - 8'h01;
                    end
                    else
                        timer_reg <= timer_reg + 24'h000001;
                end
                ST_WAIT:
                begin
                    // programmed step spacing
                    // pulse, wait and check cycles add up to one interval
                    if (timer_reg >= gap_cyc - 24'(STEP_PULSE_CYC) - 24'h000002)
                    begin
                        timer_reg <= 24'h000000;
                        state_reg <= ST_CHECK;
                    end
                    else
                        timer_reg <= timer_reg + 24'h000001;
                end
                ST_CHECK:
                begin
                    if (recal_reg)
                    begin
                        if (trk0)
                        begin
                            done <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else if (last_pulse)
                        begin
                            done <= 1'b1;
                            fail <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            count_reg <= count_reg + 8'h01;
                            state_reg <= ST_PULSE;
                        end
                    end
                    else if (at_target)
                    begin
                        done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else
                        state_reg <= ST_PULSE;
                end
            endcase
        end
    end
endmodule // fdcce_stepper
`default_nettype wire

// *** src/fdcce_idscan.sv ***
// read-id scanner: waits for an id field or two index pulses
`timescale 1ns/1ns
`default_nettype none
module fdcce_idscan
    import fdcce_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic index_rise,
    input wire logic id_valid,
    input wire logic [31:0] id_field,
    output logic [31:0] chrn,
    output logic done,
    output logic missing
);
    logic busy_reg;
    logic [1:0] idx_reg;
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        missing <= 1'b0;
        if (!rst_n)
        begin
            busy_reg <= 1'b0;
            idx_reg <= 2'h0;
            chrn <= 32'h00000000;
        end
        else if (start)
        begin
            busy_reg <= 1'b1;
            idx_reg <= 2'h0;
        end
        else if (busy_reg)
        begin
            if (id_valid)
            begin
                chrn <= id_field;
                done <= 1'b1;
                busy_reg <= 1'b0;
            end
            else if (index_rise && idx_reg == 2'h1)
            begin
                done <= 1'b1;
                missing <= 1'b1;
                busy_reg <= 1'b0;
            end
            else if (index_rise)
                idx_reg <= idx_reg + 2'h1;
        end
    end
endmodule // fdcce_idscan
`default_nettype wire

// *** src/fdcce_top.sv ***
// floppy control-command engine with ahb-lite register slave
// How it works
// - control commands move no data; only read-id, recal, seek interrupt
// - read-id stores c,h,r,n of the first good id field
// - no id mark by second index: code 01, missing-mark flag, end
// - recalibrate clears present cylinder, then samples track zero
// - step out with direction 0 until track zero; then seek-end
// - still not track zero after 79 pulses: seek-end and equipment-check
// - busy only in command phase, for read-id until it ends; drives seek in parallel
// - seek direction 1 if present below target, else 0
// - step spacing follows the programmed step-rate interval
// - after each step compare; on match set seek-end and end
// - seek and recal have no result; head bit reads 0
// - leaving power-down clears cylinders and pending status
// - interrupt on read-id result and end of seek or recal
// - interrupt query clears interrupt and reports code and seek-end
// - cause codes: poll 0/11, normal 1/00, abnormal 1/01
// - drive stays busy until interrupt query is issued
// - drive status query goes straight to result in status three
`timescale 1ns/1ns
`default_nettype none
module fdcce_top
    import fdcce_pkg::*;
#(
    parameter int SRT_UNIT = SRT_UNIT_CYC
)(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TRACK_ZERO_IN,
    input wire logic INDEX_PULSE_IN,
    input wire logic WRITE_PROTECT_IN,
    input wire logic ID_VALID,
    input wire logic [31:0] ID_FIELD,
    output logic [1:0] DRIVE_SEL,
    output logic STEP,
    output logic DIR,
    output logic INT
);
    // =====================================================================
    // bus slave
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic take;
    logic cmd_wr;
    logic cfg_wr;
    assign take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign cmd_wr = wr_pend_reg && (addr_reg == CMD_OFF);
    assign cfg_wr = wr_pend_reg && (addr_reg == CONFIG_OFF);
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= take && HWRITE;
            if (take)
                addr_reg <= HADDR[7:0];
        end
    end
    // =====================================================================
    // pin synchronisers: three flops, change counted when 2 and 3 agree
    logic [2:0] trk_sync;
    logic [2:0] idx_sync;
    logic [2:0] wp_sync;
    logic trk0_reg;
    logic idx_reg;
    logic idx_prev;
    logic wp_reg;
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            trk_sync <= 3'h0;
            idx_sync <= 3'h7;
            wp_sync <= 3'h0;
            trk0_reg <= 1'b0;
            idx_reg <= 1'b0;
            idx_prev <= 1'b0;
            wp_reg <= 1'b0;
        end
        else
        begin
            trk_sync <= {trk_sync[1:0], TRACK_ZERO_IN};
            idx_sync <= {idx_sync[1:0], INDEX_PULSE_IN};
            wp_sync <= {wp_sync[1:0], WRITE_PROTECT_IN};
            // track zero pin active high: high level on line means at track 0 here
            if (trk_sync[1] == trk_sync[2])
                trk0_reg <= trk_sync[2];
            if (idx_sync[1] == idx_sync[2])
                idx_reg <= ~idx_sync[2];
            if (wp_sync[1] == wp_sync[2])
                wp_reg <= wp_sync[2];
            idx_prev <= idx_reg;
        end
    end
    // =====================================================================
    // command decode
    logic [3:0] op;
    logic [1:0] cmd_drv;
    logic [7:0] cmd_tgt;
    logic pd_reg;
    logic pu_cmd;
    logic live;
    assign op = HWDATA[3:0];
    assign cmd_drv = HWDATA[5:4];
    assign cmd_tgt = HWDATA[15:8];
    assign live = cmd_wr && !pd_reg;
    assign pu_cmd = cmd_wr && (op == OP_POWER_UP) && pd_reg;
    logic [3:0] srt_reg;
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            srt_reg <= SRT_RESET;
        else if (cfg_wr)
            srt_reg <= HWDATA[3:0];
    end
    // =====================================================================
    // drives
    logic [NUM_DRIVES-1:0] drv_step;
    logic [NUM_DRIVES-1:0] drv_dir;
    logic [NUM_DRIVES-1:0] drv_active;
    logic [NUM_DRIVES-1:0] drv_done;
    logic [NUM_DRIVES-1:0] drv_fail;
    logic [7:0] drv_cyl [NUM_DRIVES];
    logic [NUM_DRIVES-1:0] pend_reg;
    logic [NUM_DRIVES-1:0] abn_reg;
    logic [NUM_DRIVES-1:0] ecf_reg;
    logic [NUM_DRIVES-1:0] drv_hit;
    logic [1:0] sel_reg;
    logic rid_pend_reg;
    logic rid_abn_reg;
    logic poll_reg;
    logic sense_cmd;
    logic [1:0] pick;
    logic any_pend;
    assign sense_cmd = live && (op == OP_SENSE_INT);
    // lowest pending drive is reported first
    assign pick = pend_reg[0] ? 2'd0 : pend_reg[1] ? 2'd1 : pend_reg[2] ? 2'd2 : 2'd3;
    assign any_pend = |pend_reg;
    genvar g;
    generate
        for (g = 0; g < NUM_DRIVES; g = g + 1)
        begin : g_drv
            assign drv_hit[g] = live && (cmd_drv == 2'(g));
            fdcce_stepper #(.UNIT_CYC(SRT_UNIT)) u_stp (
                .clk(CLOCK),
                .rst_n(RST_N),
                .start_seek(drv_hit[g] && (op == OP_SEEK)),
                .start_recal(drv_hit[g] && (op == OP_RECAL)),
                .clear_cyl(pu_cmd),
                .target(cmd_tgt),
                .step_rate_interval(srt_reg),
                .trk0(trk0_reg),
                .cyl(drv_cyl[g]),
                .step(drv_step[g]),
                .dir(drv_dir[g]),
                .active(drv_active[g]),
                .done(drv_done[g]),
                .fail(drv_fail[g])
            );
            always_ff @(posedge CLOCK)
            begin
                if (!RST_N || pu_cmd)
                begin
                    pend_reg[g] <= 1'b0;
                    abn_reg[g] <= 1'b0;
                    ecf_reg[g] <= 1'b0;
                end
                // end of seek or recal sets pending, set beats clear
                else if (drv_done[g])
                begin
                    pend_reg[g] <= 1'b1;
                    abn_reg[g] <= drv_fail[g];
                    ecf_reg[g] <= drv_fail[g];
                end
                else if (sense_cmd && !rid_pend_reg && pick == 2'(g))
                    pend_reg[g] <= 1'b0;
            end
        end
    endgenerate
    // only one drive on the cable is selected; its stepper drives the pins
    assign STEP = drv_step[sel_reg];
    assign DIR = drv_dir[sel_reg];
    assign DRIVE_SEL = sel_reg;
    // =====================================================================
    // read id
    logic rid_done;
    logic rid_miss;
    logic [31:0] rid_chrn;
    logic rid_busy_reg;
    fdcce_idscan u_id (
        .clk(CLOCK),
        .rst_n(RST_N),
        .start(live && (op == OP_READ_ID)),
        .index_rise(idx_reg && !idx_prev),
        .id_valid(ID_VALID),
        .id_field(ID_FIELD),
        .chrn(rid_chrn),
        .done(rid_done),
        .missing(rid_miss)
    );
    // =====================================================================
    // results and interrupt
    logic [7:0] res0_reg;
    logic [7:0] res1_reg;
    logic res_valid_reg;
    logic [7:0] st0_seek;
    logic [7:0] st0_rid;
    logic [7:0] st3;
    logic cmd_phase_reg;
    // head bit zero for seek status, taken from the id field for read-id; cause encoding
    assign st0_seek = {abn_reg[pick] ? IC_ABNORMAL : IC_NORMAL, 1'b1, ecf_reg[pick],
        1'b0, 1'b0, pick};
    assign st0_rid = {(rid_done ? rid_miss : rid_abn_reg) ? IC_ABNORMAL : IC_NORMAL, 1'b0, 1'b0, 1'b0,
        rid_chrn[16], sel_reg};
    assign st3 = {1'b0, wp_reg, 1'b1, trk0_reg, 1'b1, 1'b0, sel_reg};
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || pu_cmd)
        begin
            res0_reg <= 8'h00;
            res1_reg <= 8'h00;
            res_valid_reg <= 1'b0;
            rid_pend_reg <= 1'b0;
            rid_abn_reg <= 1'b0;
            rid_busy_reg <= 1'b0;
            poll_reg <= !RST_N;
            sel_reg <= 2'h0;
            cmd_phase_reg <= 1'b0;
            pd_reg <= 1'b0;
        end
        else
        begin
            // busy only through the command phase
            cmd_phase_reg <= live && (op == OP_SEEK || op == OP_RECAL || op == OP_READ_ID);
            if (live && (op == OP_SEEK || op == OP_RECAL || op == OP_READ_ID))
                sel_reg <= cmd_drv;
            if (live && op == OP_POWER_DOWN)
                pd_reg <= 1'b1;
            if (live && op == OP_READ_ID)
                rid_busy_reg <= 1'b1;
            if (rid_done)
            begin
                rid_busy_reg <= 1'b0;
                rid_pend_reg <= 1'b1;
                rid_abn_reg <= rid_miss;
                res0_reg <= st0_rid;
                res1_reg <= {7'h00, rid_miss} << ST1_MA_BIT;
                res_valid_reg <= 1'b1;
            end
            // query clears interrupt and reports cause
            else if (sense_cmd)
            begin
                res_valid_reg <= 1'b1;
                poll_reg <= 1'b0;
                if (rid_pend_reg)
                begin
                    rid_pend_reg <= 1'b0;
                    res0_reg <= st0_rid;
                    res1_reg <= rid_chrn[31:24];
                end
                else if (any_pend)
                begin
                    res0_reg <= st0_seek;
                    res1_reg <= drv_cyl[pick];
                end
                else
                begin
                    res0_reg <= {poll_reg ? IC_POLL : IC_ABNORMAL, 6'h00};
                    res1_reg <= 8'h00;
                end
            end
            else if (live && op == OP_SENSE_DRV)
            begin
                res0_reg <= st3;
                res1_reg <= 8'h00;
                res_valid_reg <= 1'b1;
            end
        end
    end
    assign INT = any_pend || rid_pend_reg || poll_reg;
    // =====================================================================
    // read mux
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    assign stat_word = {24'h000000, drv_active | pend_reg, pd_reg, INT, res_valid_reg,
        cmd_phase_reg || rid_busy_reg};
    assign rd_mux = (addr_reg == STATUS_OFF) ? stat_word :
        (addr_reg == RESULT_OFF) ? {16'h0000, res1_reg, res0_reg} :
        (addr_reg == CONFIG_OFF) ? {28'h0000000, srt_reg} :
        (addr_reg == ID_OFF) ? rid_chrn :
        (addr_reg == PCYL_OFF) ? {drv_cyl[3], drv_cyl[2], drv_cyl[1], drv_cyl[0]} :
        32'h00000000;
    assign HRDATA = rd_mux;
    // =====================================================================
    // checks
    property p_recal_dir;
        @(posedge CLOCK) disable iff (!RST_N)
        (drv_active[0] && !drv_step[0] && g_drv[0].u_stp.recal_reg) |-> !drv_dir[0];
    endproperty
    a_recal_dir: assert property (p_recal_dir) else $error("recal dir not zero");
    property p_seek_dir;
        @(posedge CLOCK) disable iff (!RST_N)
        (live && op == OP_SEEK && cmd_drv == 2'd0 && drv_cyl[0] < cmd_tgt
            && !pu_cmd) |=> drv_dir[0];
    endproperty
    a_seek_dir: assert property (p_seek_dir) else $error("seek in dir wrong");
    property p_done_int;
        @(posedge CLOCK) disable iff (!RST_N)
        (drv_done[1] && !pu_cmd) |=> INT && pend_reg[1];
    endproperty
    a_done_int: assert property (p_done_int) else $error("no interrupt at seek end");
    property p_sense_clr;
        @(posedge CLOCK) disable iff (!RST_N)
        (sense_cmd && pend_reg == 4'b0001 && !rid_pend_reg && !poll_reg
            && drv_done == 4'h0) |=> !INT;
    endproperty
    a_sense_clr: assert property (p_sense_clr) else $error("query kept interrupt");
    property p_head_zero;
        @(posedge CLOCK) disable iff (!RST_N)
        (sense_cmd && !rid_pend_reg && any_pend) |=> !res0_reg[ST0_H_BIT] && res0_reg[ST0_SE_BIT];
    endproperty
    a_head_zero: assert property (p_head_zero) else $error("head bit set");
    property p_fail_ec;
        @(posedge CLOCK) disable iff (!RST_N)
        (drv_fail[0] && !pu_cmd) |=> abn_reg[0] && ecf_reg[0];
    endproperty
    a_fail_ec: assert property (p_fail_ec) else $error("recal fail flags");
    property p_wake;
        @(posedge CLOCK) disable iff (!RST_N)
        pu_cmd |=> (drv_cyl[0] == 8'h00) && (pend_reg == 4'h0) && !res_valid_reg;
    endproperty
    a_wake: assert property (p_wake) else $error("wake left state");
    property p_miss;
        @(posedge CLOCK) disable iff (!RST_N)
        (rid_done && rid_miss && !pu_cmd) |=> rid_abn_reg && res1_reg[ST1_MA_BIT];
    endproperty
    a_miss: assert property (p_miss) else $error("missing mark not flagged");
    property p_busy;
        @(posedge CLOCK) disable iff (!RST_N)
        (live && op == OP_SEEK && !pu_cmd) |=> stat_word[STAT_BUSY_BIT] ##1 !cmd_phase_reg;
    endproperty
    a_busy: assert property (p_busy) else $error("busy phase wrong");
endmodule // fdcce_top
`default_nettype wire

// *** tb/fdcce_drive_model.sv ***
// behavioural floppy drive: head position, track zero, index
`timescale 1ns/1ns
`default_nettype none
module fdcce_drive_model #(
    parameter int START_CYL = 5
)(
    input wire logic clk,
    input wire logic step,
    input wire logic dir,
    input wire logic idx_en,
    output logic trk0,
    output logic idx_n
);
    int pos = START_CYL;
    int cnt = 0;
    int ctr = 0;
    int span = 0;
    logic step_d = 1'b0;
    always @(posedge clk)
    begin
        step_d <= step;
        if (step && !step_d)
            pos <= dir ? pos + 1 : pos - (pos > 0);
        // cycles between the last two step starts
        if (step && !step_d)
            span <= ctr;
        ctr <= (step && !step_d) ? 1 : ctr + 1;
        cnt <= (cnt + 1) % 100;
    end
    assign trk0 = (pos == 0);
    assign idx_n = !(idx_en && cnt < 5);
endmodule // fdcce_drive_model
`default_nettype wire

// *** tb/test_floppy_control_command_engine.sv ***
// self-checking bench for the floppy control-command engine
`timescale 1ns/1ns
`default_nettype none
module test_floppy_control_command_engine
    import fdcce_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, idv = 1'b0, idx_en = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic trk0, idx_n, hrdy, step, dir, int_o, hresp;
    logic [1:0] dsel;
    int miscompares = 0, num_checks = 0;
    always #10 clk = ~clk;
    // short step unit keeps the 79-pulse recalibrate quick
    // id field carries size code 02 of 512-byte sectors
    fdcce_top #(.SRT_UNIT(10)) uut (.CLOCK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .TRACK_ZERO_IN(trk0),
        .INDEX_PULSE_IN(idx_n), .WRITE_PROTECT_IN(1'b1), .ID_VALID(idv),
        .ID_FIELD(32'h01000502), .DRIVE_SEL(dsel), .STEP(step), .DIR(dir), .INT(int_o));
    // head starts beyond reach of one recalibrate
    fdcce_drive_model #(.START_CYL(100)) drv (.clk(clk), .step(step), .dir(dir),
        .idx_en(idx_en), .trk0(trk0), .idx_n(idx_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic cmd(input logic [3:0] op, input logic [7:0] cyl);
        bus(1'b1, CMD_OFF, {16'h0, cyl, 4'h0, op});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic wait_int;
        for (int n = 0; n < 20000 && int_o !== 1'b1; n++) @(posedge clk);
        chk({31'h0, int_o}, 32'h1);
    endtask
    task automatic sense(input logic [15:0] e);
        cmd(OP_SENSE_INT, 8'h00);
        rd(RESULT_OFF, 32'hFFFF, {16'h0, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // hang guard, well above the longest run
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end
    // ==========================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(CONFIG_OFF, 32'hF, 32'h8);
        bus(1'b1, CONFIG_OFF, 32'h6);
        rd(CONFIG_OFF, 32'hF, 32'h6);
        chk({31'h0, int_o}, 32'h1);
        sense(16'h00C0);
        chk({31'h0, int_o}, 32'h0);
        $display("test reset done");
        cmd(OP_RECAL, 8'h00);
        rd(STATUS_OFF, 32'h11, 32'h10);
        wait_int;
        sense(16'h0070);
        cmd(OP_RECAL, 8'h00);
        wait_int;
        sense(16'h0020);
        chk(drv.pos, 0);
        $display("test recalibrate done");
        cmd(OP_SEEK, 8'h03);
        wait_int;
        rd(PCYL_OFF, 32'hFF, 32'h3);
        chk(drv.span, (16 - 6) * 10);
        sense(16'h0320);
        chk(drv.pos, 3);
        cmd(OP_SEEK, 8'h01);
        wait_int;
        sense(16'h0120);
        chk(drv.pos, 1);
        // drive one keeps its own cylinder count and steps the shared cable
        bus(1'b1, CMD_OFF, {16'h0, 8'h02, 4'h1, OP_SEEK});
        wait_int;
        chk({30'h0, dsel}, 32'h1);
        sense(16'h0221);
        chk(drv.pos, 3);
        $display("test seek done");
        cmd(OP_READ_ID, 8'h00);
        idv <= 1'b1;
        @(posedge clk);
        idv <= 1'b0;
        wait_int;
        rd(ID_OFF, 32'hFFFFFFFF, 32'h01000502);
        sense(16'h0100);
        idx_en <= 1'b1;
        cmd(OP_READ_ID, 8'h00);
        wait_int;
        idx_en <= 1'b0;
        rd(RESULT_OFF, 32'hFFFF, 32'h0140);
        cmd(OP_SENSE_INT, 8'h00);
        rd(RESULT_OFF, 32'hFFFF, 32'h0140);
        cmd(OP_SENSE_DRV, 8'h00);
        rd(RESULT_OFF, 32'hFF, 32'h68);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, int_o}, 32'h0);
        $display("test query done");
        cmd(OP_POWER_DOWN, 8'h00);
        cmd(OP_POWER_UP, 8'h00);
        rd(PCYL_OFF, 32'hFFFFFFFF, 32'h0);
        $display("test power done");
        report_and_stop;
    end
endmodule // test_floppy_control_command_engine
`default_nettype wire
